// ---- qdr_bank.sv ----
// queue doorbell register bank: admin queue bases, doorbells, indirect index/data pair
// assumes host requests arrive on mclk, one per cycle, from the function's bus logic
//
// Operation
// - admin submission base 64 bits, 63:12 writable, 11:0 read zero
// - admin completion base 64 bits, 63:12 writable, low bits read zero
// - admin completion postings always use interrupt vector zero
// - submission tail doorbell at 1000h plus 8y, 16-bit value, upper bits zero
// - completion head doorbell at 1004h plus 8y, 16-bit value
// - tail write replaces tail; wrapped difference is count of new commands
// - head write replaces head; wrapped difference is count of freed slots
// - invalid doorbell value posts asynchronous event to admin completion queue
// - full completion queue withholds postings; its feeding submission queue pauses
// - queue empty exactly when head equals tail
// - queue full when head equals tail plus one with wrap
// - submitter writes at tail then advances, wrapping to zero past size
// - consumer takes at head then advances, wrapping to zero past size
// - index register bits 31:2 hold register offset, low bits zero
// - data register forwards accesses to register chosen by index
// - index/data pair lives only in the I/O space region
// - enable clear resets pointers but keeps admin queue base registers
// - page size is two to the twelve plus page field, 4KB minimum
`include "qdr_regs.svh"
module qdr_bank (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire qdr_pkg::qdr_req_t req,
    output logic rsp_valid_q,
    output logic [31:0] rsp_data_q,
    input wire logic controller_enable_bit,
    input wire logic [3:0] page_size_field,
    input wire logic [`QDR_NQ-1:0] queue_alloc,
    input wire logic [`QDR_NQ-1:0][15:0] sq_size,
    input wire logic [`QDR_NQ-1:0][15:0] cq_size,
    input wire logic fetch_req,
    input wire logic [1:0] fetch_qid,
    output logic fetch_grant_q,
    input wire logic post_req,
    input wire logic [1:0] post_qid,
    output logic post_grant_q,
    output logic [15:0] post_vector_q,
    output logic evt_valid_q,
    output qdr_pkg::qdr_evt_t evt_q,
    output logic admin_event_q,
    output logic [`QDR_NQ-1:0] sq_empty_q,
    output logic [`QDR_NQ-1:0] cq_full_q,
    output logic [63:0] admin_submission_base_q,
    output logic [63:0] admin_completion_base_q,
    output logic base_misaligned_q
);
    import qdr_pkg::*;
    localparam int NQ = `QDR_NQ;
    localparam int QW = $clog2(NQ);

    function automatic qdr_ptr_t wrap_diff(qdr_ptr_t a, qdr_ptr_t b, qdr_ptr_t size);
        logic [16:0] d;
        d = {1'b0, a} - {1'b0, b};
        if (a < b) begin
            d = d + {1'b0, size} + 17'h00001;
        end
        return d[15:0];
    endfunction : wrap_diff

    function automatic qdr_ptr_t next_ptr(qdr_ptr_t p, qdr_ptr_t size);
        return (p == size) ? `QDR_PTR_RST : qdr_ptr_t'(p + 16'h0001);
    endfunction : next_ptr

    logic [51:0] asq_q;
    logic [51:0] acq_q;
    logic [29:0] idx_q;
    qdr_ptr_t sq_tail_q [NQ];
    qdr_ptr_t sq_head_q [NQ];
    qdr_ptr_t cq_head_q [NQ];
    qdr_ptr_t cq_tail_q [NQ];
    logic en_q;
    logic ctrl_rst;
    logic dat_sel;
    logic mmio_sel;
    logic [15:0] eff_addr;
    logic [15:0] db_off;
    logic db_hit;
    logic [QW-1:0] db_q;
    logic db_is_cq;
    logic db_alloc;
    logic db_wr;
    qdr_ptr_t db_val;
    qdr_ptr_t db_cnt;
    qdr_ptr_t db_room;
    logic db_bad;
    logic wr;
    logic [31:0] rd_data;
    logic [NQ-1:0] alloc;
    logic [NQ-1:0] sq_empty;
    logic [NQ-1:0] cq_full;
    logic fetch_ok;
    logic post_ok;
    logic [51:0] page_mask;

    // controller reset on enable falling edge; bases survive it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
        end else begin
            en_q <= controller_enable_bit;
        end
    end
    assign ctrl_rst = en_q && !controller_enable_bit;
    assign alloc = {queue_alloc[NQ-1:1], controller_enable_bit};

    always_comb begin
        wr = req_valid && req.write;
        dat_sel = req.io_space && req.addr == `QDR_DAT_OFF;
        eff_addr = dat_sel ? {idx_q[13:0], 2'b00} : req.addr;
        mmio_sel = !req.io_space || dat_sel;
        db_off = eff_addr - `QDR_SQ_DB_BASE;
        db_q = db_off[`QDR_DB_SHIFT +: QW];
        db_is_cq = db_off[2];
        db_hit = mmio_sel && eff_addr >= `QDR_SQ_DB_BASE && eff_addr[1:0] == 2'b00
            && db_off[15:`QDR_DB_SHIFT] < 13'(NQ);
        db_alloc = alloc[db_q];
        db_wr = wr && db_hit && db_alloc;
        db_val = req.wdata[15:0];
        if (db_is_cq) begin
            db_cnt = wrap_diff(db_val, cq_head_q[db_q], cq_size[db_q]);
            db_room = wrap_diff(cq_tail_q[db_q], cq_head_q[db_q], cq_size[db_q]);
        end else begin
            db_cnt = wrap_diff(db_val, sq_tail_q[db_q], sq_size[db_q]);
            db_room = sq_size[db_q] - wrap_diff(sq_tail_q[db_q], sq_head_q[db_q],
                sq_size[db_q]);
        end
        // pointer outside queue, or moving past the other pointer
        db_bad = db_val > (db_is_cq ? cq_size[db_q] : sq_size[db_q]) || db_cnt > db_room;
    end

    always_comb begin
        for (int i = 0; i < NQ; i++) begin
            sq_empty[i] = sq_head_q[i] == sq_tail_q[i];
            cq_full[i] = cq_head_q[i] == next_ptr(cq_tail_q[i], cq_size[i]);
        end
    end

    // a submission queue pauses while its completion queue is full
    assign fetch_ok = fetch_req && alloc[fetch_qid] && !sq_empty[fetch_qid]
        && !cq_full[fetch_qid];
    assign post_ok = post_req && alloc[post_qid] && !cq_full[post_qid];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            asq_q <= `QDR_BASE_RST;
        end else if (wr && mmio_sel && eff_addr == `QDR_ASQ_LO_OFF) begin
            asq_q[19:0] <= req.wdata[31:`QDR_BASE_LSB];
        end else if (wr && mmio_sel && eff_addr == `QDR_ASQ_HI_OFF) begin
            asq_q[51:20] <= req.wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acq_q <= `QDR_BASE_RST;
        end else if (wr && mmio_sel && eff_addr == `QDR_ACQ_LO_OFF) begin
            acq_q[19:0] <= req.wdata[31:`QDR_BASE_LSB];
        end else if (wr && mmio_sel && eff_addr == `QDR_ACQ_HI_OFF) begin
            acq_q[51:20] <= req.wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q <= `QDR_IDX_RST;
        end else if (wr && req.io_space && req.addr == `QDR_IDX_OFF) begin
            idx_q <= req.wdata[31:`QDR_IDX_LSB];
        end
    end

    // host-owned pointers: tail of submission, head of completion
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NQ; i++) begin
                sq_tail_q[i] <= `QDR_PTR_RST;
                cq_head_q[i] <= `QDR_PTR_RST;
            end
        end else if (ctrl_rst) begin
            for (int i = 0; i < NQ; i++) begin
                sq_tail_q[i] <= `QDR_PTR_RST;
                cq_head_q[i] <= `QDR_PTR_RST;
            end
        end else if (db_wr && !db_bad) begin
            if (db_is_cq) begin
                cq_head_q[db_q] <= db_val;
            end else begin
                sq_tail_q[db_q] <= db_val;
            end
        end
    end

    // device-owned pointers: head of submission, tail of completion
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NQ; i++) begin
                sq_head_q[i] <= `QDR_PTR_RST;
                cq_tail_q[i] <= `QDR_PTR_RST;
            end
        end else if (ctrl_rst) begin
            for (int i = 0; i < NQ; i++) begin
                sq_head_q[i] <= `QDR_PTR_RST;
                cq_tail_q[i] <= `QDR_PTR_RST;
            end
        end else begin
            if (fetch_ok) begin
                sq_head_q[fetch_qid] <= next_ptr(sq_head_q[fetch_qid],
                    sq_size[fetch_qid]);
            end
            if (post_ok) begin
                cq_tail_q[post_qid] <= next_ptr(cq_tail_q[post_qid], cq_size[post_qid]);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_grant_q <= 1'b0;
            post_grant_q <= 1'b0;
            post_vector_q <= `QDR_ADMIN_VECTOR;
        end else begin
            fetch_grant_q <= fetch_ok && !ctrl_rst;
            post_grant_q <= post_ok && !ctrl_rst;
            if (post_ok) begin
                // other queues take their id as vector until vector tables exist
                post_vector_q <= (post_qid == 2'b00) ? `QDR_ADMIN_VECTOR
                    : {14'h0000, post_qid};
            end
        end
    end

    // doorbell event carries the wrapped count to the fetch or post engine
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            evt_valid_q <= 1'b0;
            evt_q <= '0;
            admin_event_q <= 1'b0;
        end else begin
            evt_valid_q <= db_wr && !ctrl_rst;
            admin_event_q <= db_wr && db_bad && !ctrl_rst;
            if (db_wr) begin
                evt_q <= '{is_cq: db_is_cq, invalid: db_bad, qid: 16'(db_q), count: db_cnt};
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sq_empty_q <= '1;
            cq_full_q <= '0;
        end else begin
            sq_empty_q <= sq_empty;
            cq_full_q <= cq_full;
        end
    end

    // page is 2^(12+field); base bits above bit 11 but below page must be zero
    always_comb begin
        page_mask = ~({52{1'b1}} << page_size_field);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            base_misaligned_q <= 1'b0;
        end else begin
            base_misaligned_q <= |(asq_q & page_mask) || |(acq_q & page_mask);
        end
    end

    assign admin_submission_base_q = {asq_q, 12'h000};
    assign admin_completion_base_q = {acq_q, 12'h000};

    always_comb begin
        rd_data = 32'h0000_0000;
        if (req.io_space && req.addr == `QDR_IDX_OFF) begin
            rd_data = {idx_q, 2'b00};
        end else if (mmio_sel) begin
            if (db_hit) begin
                // undefined for the host; stored value returned, upper half zero
                rd_data = {16'h0000, db_is_cq ? cq_head_q[db_q] : sq_tail_q[db_q]};
            end else if (eff_addr == `QDR_ASQ_LO_OFF) begin
                rd_data = {asq_q[19:0], 12'h000};
            end else if (eff_addr == `QDR_ASQ_HI_OFF) begin
                rd_data = asq_q[51:20];
            end else if (eff_addr == `QDR_ACQ_LO_OFF) begin
                rd_data = {acq_q[19:0], 12'h000};
            end else if (eff_addr == `QDR_ACQ_HI_OFF) begin
                rd_data = acq_q[51:20];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 32'h0000_0000;
        end else begin
            rsp_valid_q <= req_valid;
            rsp_data_q <= (req_valid && !req.write) ? rd_data : 32'h0000_0000;
        end
    end

    sequence s_bad_db;
        db_wr && db_bad && !ctrl_rst;
    endsequence
    sequence s_admin_post;
        post_ok && !ctrl_rst && post_qid == 2'b00;
    endsequence

    property p_asq_low_zero;
        @(posedge mclk) disable iff (!rst_n)
        req_valid && !req.write && mmio_sel && eff_addr == `QDR_ASQ_LO_OFF
            |=> rsp_valid_q && rsp_data_q[11:0] == 12'h000;
    endproperty
    a_asq_low_zero: assert property (p_asq_low_zero) else $error("asq low bits not zero");

    property p_acq_low_zero;
        @(posedge mclk) disable iff (!rst_n)
        req_valid && !req.write && mmio_sel && eff_addr == `QDR_ACQ_LO_OFF
            |=> rsp_valid_q && rsp_data_q[11:0] == 12'h000;
    endproperty
    a_acq_low_zero: assert property (p_acq_low_zero) else $error("acq low bits not zero");

    property p_admin_vector;
        @(posedge mclk) disable iff (!rst_n)
        s_admin_post |=> post_grant_q && post_vector_q == `QDR_ADMIN_VECTOR;
    endproperty
    a_admin_vector: assert property (p_admin_vector) else $error("admin post not on vector 0");

    property p_db_upper_zero;
        @(posedge mclk) disable iff (!rst_n)
        req_valid && !req.write && db_hit |=> rsp_data_q[31:16] == 16'h0000;
    endproperty
    a_db_upper_zero: assert property (p_db_upper_zero) else $error("doorbell upper bits set");

    property p_tail_count;
        @(posedge mclk) disable iff (!rst_n)
        db_wr && !db_bad && !db_is_cq && !ctrl_rst |=> evt_valid_q && !evt_q.is_cq
            && evt_q.count == wrap_diff(sq_tail_q[$past(db_q)], $past(sq_tail_q[db_q]),
            $past(sq_size[db_q]));
    endproperty
    a_tail_count: assert property (p_tail_count) else $error("tail count mismatch");

    property p_bad_event;
        @(posedge mclk) disable iff (!rst_n)
        s_bad_db |=> admin_event_q && evt_valid_q && evt_q.invalid;
    endproperty
    a_bad_event: assert property (p_bad_event) else $error("invalid doorbell not reported");

    // event pulse only follows a refused value, never a good write
    property p_event_only_bad;
        @(posedge mclk) disable iff (!rst_n)
        !(db_wr && db_bad) |=> !admin_event_q;
    endproperty
    a_event_only_bad: assert property (p_event_only_bad) else $error("spurious event");

    property p_no_post_full;
        @(posedge mclk) disable iff (!rst_n)
        post_req && cq_full[post_qid] |=> !post_grant_q;
    endproperty
    a_no_post_full: assert property (p_no_post_full) else $error("posted to full queue");

    property p_no_fetch_empty;
        @(posedge mclk) disable iff (!rst_n)
        fetch_req && sq_head_q[fetch_qid] == sq_tail_q[fetch_qid] |=> !fetch_grant_q;
    endproperty
    a_no_fetch_empty: assert property (p_no_fetch_empty) else $error("fetched from empty queue");

    property p_keep_base;
        @(posedge mclk) disable iff (!rst_n)
        ctrl_rst && !wr |=> $stable(asq_q) && $stable(acq_q) && sq_tail_q[0] == `QDR_PTR_RST;
    endproperty
    a_keep_base: assert property (p_keep_base) else $error("controller reset broke bases");

    property p_unalloc;
        @(posedge mclk) disable iff (!rst_n)
        wr && db_hit && !db_alloc && !ctrl_rst |=> !evt_valid_q && $stable(sq_tail_q[0])
            && $stable(sq_tail_q[1]) && $stable(sq_tail_q[2]) && $stable(sq_tail_q[3]);
    endproperty
    a_unalloc: assert property (p_unalloc) else $error("unallocated doorbell took effect");
endmodule : qdr_bank

// ---- qdr_regs.svh ----
// offsets, field positions, reset values and counts of the queue doorbell register bank
// assumes byte addressing with one aligned 32-bit word per register
`ifndef QDR_REGS_SVH
`define QDR_REGS_SVH
`define QDR_IDX_OFF 16'h0000
`define QDR_DAT_OFF 16'h0004
`define QDR_ASQ_LO_OFF 16'h0028
`define QDR_ASQ_HI_OFF 16'h002C
`define QDR_ACQ_LO_OFF 16'h0030
`define QDR_ACQ_HI_OFF 16'h0034
`define QDR_SQ_DB_BASE 16'h1000
`define QDR_CQ_DB_BASE 16'h1004
`define QDR_DB_SHIFT 3
`define QDR_BASE_LSB 12
`define QDR_IDX_LSB 2
`define QDR_PAGE_SHIFT_MIN 5'h0C
`define QDR_BASE_RST 52'h0
`define QDR_PTR_RST 16'h0000
`define QDR_IDX_RST 30'h0
`define QDR_NQ 4
`define QDR_ADMIN_VECTOR 16'h0000
`endif

// ---- qdr_pkg.sv ----
// types shared by the queue doorbell register bank
// assumes the constants header is compiled alongside
package qdr_pkg;
    typedef logic [15:0] qdr_ptr_t;
    typedef struct packed {
        logic io_space;
        logic write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } qdr_req_t;
    typedef struct packed {
        logic is_cq;
        logic invalid;
        logic [15:0] qid;
        qdr_ptr_t count;
    } qdr_evt_t;
endpackage : qdr_pkg

// ---- qdr_host_model.sv ----
// host software model: issues one register request at a time on the bank's request bus
// assumes the bank answers exactly one mclk cycle after each request it takes
module qdr_host_model (
    mclk,
    req_valid,
    req,
    rsp_valid_q,
    rsp_data_q
);
    import qdr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    input wire logic mclk;
    output qdr_pkg::qdr_req_t req;
    output logic req_valid;
    input wire logic rsp_valid_q;
    input wire logic [31:0] rsp_data_q;
    int misses;
    initial begin
        req_valid = 1'b0;
        req = '0;
        misses = 0;
    end
    // single request; fields inverted once released so stale values never look live
    task automatic access(input logic io, input logic wr, input logic [15:0] addr,
                          input logic [31:0] wdata, output logic [31:0] rdata);
        @(posedge mclk);
        req_valid <= 1'b1;
        req <= '{io_space: io, write: wr, addr: addr, wdata: wdata};
        @(posedge mclk);
        req_valid <= 1'b0;
        req <= ~req;
        #1;
        if (rsp_valid_q !== 1'b1) begin
            misses++;
        end
        rdata = rsp_data_q;
    endtask : access
endmodule : qdr_host_model

// ---- qdr_bank_test.sv ----
// self-checking bench of the queue doorbell register bank
// assumes qdr_pkg, qdr_regs.svh and the host model are compiled first
`include "qdr_regs.svh"
module qdr_bank_test;
    import qdr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_n, req_valid, rsp_valid_q, en, fetch_req, post_req;
    logic fetch_grant_q, post_grant_q, evt_valid_q, admin_event_q, base_misaligned_q;
    qdr_req_t req;
    qdr_evt_t evt_q;
    logic [31:0] rsp_data_q, rd;
    logic [3:0] page_size_field, queue_alloc, sq_empty_q, cq_full_q;
    logic [3:0][15:0] sq_size, cq_size;
    logic [1:0] fetch_qid, post_qid;
    logic [15:0] post_vector_q, tl, hd, v;
    logic [16:0] e;
    logic [63:0] asq_q, acq_q, b;
    int errors, total_checks;

    qdr_bank u_dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q), .controller_enable_bit(en),
        .page_size_field(page_size_field), .queue_alloc(queue_alloc), .sq_size(sq_size),
        .cq_size(cq_size), .fetch_req(fetch_req), .fetch_qid(fetch_qid),
        .fetch_grant_q(fetch_grant_q), .post_req(post_req), .post_qid(post_qid),
        .post_grant_q(post_grant_q), .post_vector_q(post_vector_q),
        .evt_valid_q(evt_valid_q), .evt_q(evt_q), .admin_event_q(admin_event_q),
        .sq_empty_q(sq_empty_q), .cq_full_q(cq_full_q), .admin_submission_base_q(asq_q),
        .admin_completion_base_q(acq_q), .base_misaligned_q(base_misaligned_q));
    qdr_host_model u_host (.mclk(mclk), .req_valid(req_valid), .req(req),
        .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic io, input logic [15:0] a, input logic [31:0] d);
        u_host.access(io, 1'b1, a, d, rd);
    endtask : wr
    task automatic rdc(input logic io, input logic [15:0] a, input logic [31:0] exp);
        u_host.access(io, 1'b0, a, 32'h0, rd);
        chk(rd, exp);
    endtask : rdc
    // doorbell write, then the event it must or must not raise; never read back
    task automatic db(input logic cq, input logic [1:0] q, input logic [15:0] val,
                      input logic ev, input logic bad, input logic [15:0] cnt);
        wr(1'b0, 16'h1000 | {11'h0, q, cq, 2'b00}, {16'h0, val});
        chk(evt_valid_q, ev);
        chk(admin_event_q, bad);
        if (ev) begin
            chk(evt_q[33:16], {cq, bad, 14'h0, q});
        end
        if (ev && !bad) begin
            chk(evt_q.count, cnt);
        end
    endtask : db
    // back-end fetch or post request; vector equals queue id, zero for admin
    task automatic side(input logic post, input logic [1:0] q, input logic exp);
        @(posedge mclk);
        fetch_req <= !post;
        post_req <= post;
        fetch_qid <= q;
        post_qid <= q;
        @(posedge mclk);
        fetch_req <= 1'b0;
        post_req <= 1'b0;
        #1;
        chk(post ? post_grant_q : fetch_grant_q, exp);
        if (post && exp) begin
            chk(post_vector_q, {14'h0, q});
        end
    endtask : side
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask : settle
    // validity and wrapped count of a tail write to an eight-entry queue
    function automatic logic [16:0] sq_expect(input logic [15:0] val, input logic [15:0] t,
                                              input logic [15:0] h);
        logic [15:0] cnt, occ;
        cnt = (val + 16'h8 - t) % 16'h8;
        occ = (t + 16'h8 - h) % 16'h8;
        return {(val > 16'h7) || (cnt > 16'h7 - occ), cnt};
    endfunction : sq_expect

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        tally_and_finish();
    end
    initial begin
        rst_n = 1'b0;
        en = 1'b0;
        page_size_field = 4'h0;
        queue_alloc = 4'hB;
        sq_size = {4{16'h0007}};
        cq_size = {4{16'h0003}};
        fetch_req = 1'b0;
        post_req = 1'b0;
        fetch_qid = 2'h0;
        post_qid = 2'h0;
        tl = 16'h0;
        hd = 16'h0;
        errors = 0;
        total_checks = 0;
        void'($urandom(70));
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk(sq_empty_q, 4'hF);
        chk(asq_q, 64'h0);
        // indirect pair first: never used again after direct access
        wr(1'b1, 16'h0000, 32'h0000_002B);
        rdc(1'b1, 16'h0000, 32'h0000_0028);
        wr(1'b1, 16'h0004, 32'hA5A5_AFFF);
        rdc(1'b1, 16'h0004, 32'hA5A5_A000);
        rdc(1'b0, 16'h0000, 32'h0);
        rdc(1'b0, 16'h0028, 32'hA5A5_A000);
        // bases written while enable is clear
        b = {$urandom, $urandom};
        wr(1'b0, 16'h002C, b[63:32]);
        wr(1'b0, 16'h0030, b[31:0]);
        wr(1'b0, 16'h0034, b[63:32]);
        rdc(1'b0, 16'h002C, b[63:32]);
        rdc(1'b0, 16'h0030, {b[31:12], 12'h0});
        rdc(1'b0, 16'h0034, b[63:32]);
        chk(asq_q, {b[63:32], 32'hA5A5_A000});
        chk(acq_q, {b[63:12], 12'h0});
        wr(1'b0, 16'h0030, 32'h0000_3000);
        settle();
        chk(base_misaligned_q, 1'b0);
        page_size_field <= 4'h1;
        settle();
        chk(base_misaligned_q, 1'b1);
        wr(1'b0, 16'h0030, 32'h0000_4000);
        settle();
        chk(base_misaligned_q, 1'b0);
        en <= 1'b1;
        db(1'b0, 2'd0, 16'h0005, 1'b1, 1'b0, 16'h0005);
        settle();
        chk(sq_empty_q[0], 1'b0);
        for (int i = 0; i < 5; i++) begin
            side(1'b0, 2'd0, 1'b1);
        end
        settle();
        chk(sq_empty_q[0], 1'b1);
        side(1'b0, 2'd0, 1'b0);
        db(1'b0, 2'd0, 16'h0004, 1'b1, 1'b0, 16'h0007);
        db(1'b0, 2'd0, 16'h0005, 1'b1, 1'b1, 16'h0000);
        db(1'b0, 2'd0, 16'h0004, 1'b1, 1'b0, 16'h0000);
        // completion queue 1 filled by posts, then freed by head writes
        for (int i = 0; i < 3; i++) begin
            side(1'b1, 2'd1, 1'b1);
        end
        side(1'b1, 2'd1, 1'b0);
        settle();
        chk(cq_full_q[1], 1'b1);
        side(1'b1, 2'd0, 1'b1);
        db(1'b1, 2'd1, 16'h0002, 1'b1, 1'b0, 16'h0002);
        settle();
        chk(cq_full_q[1], 1'b0);
        db(1'b1, 2'd1, 16'h0000, 1'b1, 1'b1, 16'h0000);
        side(1'b1, 2'd1, 1'b1);
        db(1'b1, 2'd1, 16'h0000, 1'b1, 1'b0, 16'h0002);
        db(1'b0, 2'd2, 16'h0001, 1'b0, 1'b0, 16'h0000);
        wr(1'b0, 16'h1028, 32'h0000_0001);
        chk(evt_valid_q, 1'b0);
        // random tail writes and fetches on queue 3, corner values above size included
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            #1;
            chk(sq_empty_q[3], tl == hd);
            v = 16'($urandom_range(0, 9));
            e = sq_expect(v, tl, hd);
            db(1'b0, 2'd3, v, 1'b1, e[16], e[15:0]);
            if (!e[16]) begin
                tl = v;
            end
            if ($urandom_range(0, 1) == 1) begin
                side(1'b0, 2'd3, tl != hd);
                if (tl != hd) begin
                    hd = (hd + 16'h1) % 16'h8;
                end
            end
        end
        // controller reset clears pointers, keeps bases
        en <= 1'b0;
        settle();
        chk(sq_empty_q, 4'hF);
        chk(asq_q, {b[63:32], 32'hA5A5_A000});
        chk(acq_q, {b[63:32], 32'h0000_4000});
        chk(u_host.misses, 0);
        tally_and_finish();
    end
endmodule : qdr_bank_test
